//--- hdl/flag_ops_defs.vh
// constants for the status flag and bit transfer instruction unit
`ifndef FLAG_OPS_DEFS_VH
`define FLAG_OPS_DEFS_VH

// status flag positions
`define FLAG_C            3'h0
`define FLAG_Z            3'h1
`define FLAG_N            3'h2
`define FLAG_V            3'h3
`define FLAG_S            3'h4
`define FLAG_H            3'h5
`define FLAG_T            3'h6
`define FLAG_I            3'h7

// instruction codes; op[4]=1 is a named flag op: op[3:1] flag, op[0] 1=set 0=clear
`define OP_NOP            5'h00
`define OP_COPY_BIT       5'h01
`define OP_LOAD_BIT       5'h02
`define OP_FLAG_SET       5'h03
`define OP_FLAG_CLEAR     5'h04
`define OP_SLEEP          5'h05
`define OP_WDOG_RESTART   5'h06
`define OP_NAMED_BIT      4
`define OP_NAMED_SET_BIT  0
`define OP_CARRY_SET      5'h11
`define OP_CARRY_CLEAR    5'h10
`define OP_ZERO_SET       5'h13
`define OP_ZERO_CLEAR     5'h12
`define OP_NEG_SET        5'h15
`define OP_NEG_CLEAR      5'h14
`define OP_OVF_SET        5'h17
`define OP_OVF_CLEAR      5'h16
`define OP_SIGN_SET       5'h19
`define OP_SIGN_CLEAR     5'h18
`define OP_HALF_SET       5'h1b
`define OP_HALF_CLEAR     5'h1a
`define OP_XFER_SET       5'h1d
`define OP_XFER_CLEAR     5'h1c
`define OP_INTEN_SET      5'h1f
`define OP_INTEN_CLEAR    5'h1e

// register byte offsets
`define REG_FLAGS         4'h0
`define REG_CTRL          4'h4
`define REG_STATUS        4'h8
`define REG_COUNT         4'hc

// control field positions and reset values
`define CTRL_EXEC_EN      0
`define CTRL_SLEEP_EN     1
`define CTRL_RESET        2'h3
`define FLAGS_RESET       8'h00

// status field positions
`define STAT_SLEEPING     0
`define STAT_LAST_OP_LSB  8

// every instruction of this unit finishes in this many cycles
`define OP_CYCLES         1
`endif

//--- hdl/bit_select_merge.v
// picks one bit of a byte and builds the byte with one bit replaced
module bit_select_merge (
  input  wire [7:0] word_in,
  input  wire [2:0] bit_sel,
  input  wire       new_bit,
  output wire       picked_bit,
  output wire [7:0] merged_word
);

  wire [7:0] hit;

  // one position per bit: a decoded select steers both picking and merging
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      assign hit[i]         = ({29'd0, bit_sel} == i);
      assign merged_word[i] = hit[i] ? new_bit : word_in[i];
    end
  endgenerate

  // only one hit bit is ever high, so an and-or is a clean mux
  assign picked_bit = |(hit & word_in);

endmodule // bit_select_merge

//--- hdl/status_flag_bit_ops.v
// status flag and bit transfer instruction unit with its register slave
//
// Summary of operation
// - copy_bit_to_flag_op copies source bit b into T, one cycle, other flags kept.
// - load_bit_from_flag_op writes T into destination bit b, one cycle, flags kept.
// - overflow set and clear force V to one or zero, only V, one cycle.
// - sign set and clear force S to one or zero, only S, one cycle.
// - half-carry set and clear force H to one or zero, only H, one cycle.
// - sleep takes one cycle, keeps all flags, and requests sleep mode.
// - watchdog restart takes one cycle, keeps all flags, and pulses the restart.
//
// Decided for this implementation: register access over Avalon-MM and the address map.
`include "flag_ops_defs.vh"

module status_flag_bit_ops (
  input  wire        mclk,
  input  wire        reset,
  input  wire        clk_en,
  // instruction issue from the fetch path
  input  wire        op_valid,
  input  wire [4:0]  op_code,
  input  wire [2:0]  op_bit,
  input  wire [4:0]  op_reg_addr,
  input  wire [7:0]  op_reg_data,
  input  wire        wake,
  // results toward the register file and system
  output reg  [7:0]  status_flags_reg,
  output reg         reg_wr_en,
  output reg  [4:0]  reg_wr_addr,
  output reg  [7:0]  reg_wr_data,
  output reg         sleep_req,
  output reg         wdog_restart,
  output reg         op_done,
  // avalon-mm slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest
);

  reg  [1:0]  ctrl_r;
  reg         sleeping_r;
  reg  [4:0]  last_op_r;
  reg  [15:0] op_count_r;

  reg  [7:0]  flags_nxt;
  reg         wr_en_nxt;
  reg  [7:0]  wr_data_nxt;
  reg         sleep_nxt;
  reg         wdog_nxt;
  reg         known_op;
  reg  [31:0] rd_value;

  wire        picked_bit;
  wire [7:0]  merged_word;
  wire        exec_go;
  wire        bus_req;
  wire        bus_wr_commit;
  wire        bus_flags_wr;

  // bit pick for the copy, bit merge for the load
  bit_select_merge u_bit_select_merge (
    .word_in     (op_reg_data),
    .bit_sel     (op_bit),
    .new_bit     (status_flags_reg[`FLAG_T]),
    .picked_bit  (picked_bit),
    .merged_word (merged_word)
  );

  assign exec_go       = op_valid & ctrl_r[`CTRL_EXEC_EN];
  assign bus_req       = avs_read | avs_write;
  // a write lands only at the edge where the master sees waitrequest low
  assign bus_wr_commit = avs_write & ~avs_waitrequest;
  assign bus_flags_wr  = bus_wr_commit & (avs_address == `REG_FLAGS) & avs_byteenable[0];

  // decode: each op touches only its own flag, everything resolves in one cycle
  always @* begin
    flags_nxt   = status_flags_reg;
    wr_en_nxt   = 1'b0;
    wr_data_nxt = reg_wr_data;
    sleep_nxt   = 1'b0;
    wdog_nxt    = 1'b0;
    known_op    = 1'b1;
    // software may rewrite the flags in any cycle but one with a NOP, which keeps the old flags; else a same-cycle instruction's own flag bit wins
    if (bus_flags_wr) begin
      flags_nxt = avs_writedata[7:0];
    end
    if (exec_go) begin
      if (op_code[`OP_NAMED_BIT]) begin
        // named set/clear ops for C, Z, N, V, S, H, T and I
        flags_nxt[op_code[3:1]] = op_code[`OP_NAMED_SET_BIT];
      end else begin
        case (op_code)
          `OP_NOP: begin
            flags_nxt = status_flags_reg;
          end
          `OP_COPY_BIT: begin
            flags_nxt[`FLAG_T] = picked_bit;
          end
          `OP_LOAD_BIT: begin
            wr_en_nxt   = 1'b1;
            wr_data_nxt = merged_word;
          end
          `OP_FLAG_SET: begin
            flags_nxt[op_bit] = 1'b1;
          end
          `OP_FLAG_CLEAR: begin
            flags_nxt[op_bit] = 1'b0;
          end
          `OP_SLEEP: begin
            // flags untouched; the sleep controller decides what sleep means
            sleep_nxt = ctrl_r[`CTRL_SLEEP_EN];
          end
          `OP_WDOG_RESTART: begin
            wdog_nxt = 1'b1;
          end
          default: begin
            known_op = 1'b0;
          end
        endcase
      end
    end
  end

  // instruction results, registered so every output leaves a flop
  always @(posedge mclk) begin
    if (reset) begin
      status_flags_reg <= `FLAGS_RESET;
      reg_wr_en        <= 1'b0;
      reg_wr_addr      <= 5'h00;
      reg_wr_data      <= 8'h00;
      sleep_req        <= 1'b0;
      wdog_restart     <= 1'b0;
      op_done          <= 1'b0;
      last_op_r        <= 5'h00;
      op_count_r       <= 16'h0000;
    end else if (clk_en) begin
      status_flags_reg <= flags_nxt;
      reg_wr_en        <= wr_en_nxt;
      reg_wr_data      <= wr_data_nxt;
      sleep_req        <= sleep_nxt;
      wdog_restart     <= wdog_nxt;
      op_done          <= exec_go & known_op;
      if (exec_go) begin
        reg_wr_addr <= op_reg_addr;
      end
      // counter wraps; software reads deltas, not absolute totals
      if (exec_go & known_op) begin
        last_op_r  <= op_code;
        op_count_r <= op_count_r + 16'h0001;
      end
    end
  end

  // sleep status: the wake event wins over a sleep in the same cycle
  always @(posedge mclk) begin
    if (reset) begin
      sleeping_r <= 1'b0;
    end else if (clk_en) begin
      if (wake) begin
        sleeping_r <= 1'b0;
      end else if (sleep_nxt) begin
        sleeping_r <= 1'b1;
      end
    end
  end

  // read mux; unmapped offsets read as zero
  always @* begin
    rd_value = 32'h0000_0000;
    case (avs_address)
      `REG_FLAGS: begin
        rd_value[7:0] = status_flags_reg;
      end
      `REG_CTRL: begin
        rd_value[1:0] = ctrl_r;
      end
      `REG_STATUS: begin
        rd_value[`STAT_SLEEPING] = sleeping_r;
        rd_value[`STAT_LAST_OP_LSB +: 5] = last_op_r;
      end
      `REG_COUNT: begin
        rd_value[15:0] = op_count_r;
      end
      default: begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  // bus slave: one wait cycle, then a single ready cycle per request
  always @(posedge mclk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (clk_en) begin
      if (bus_req & avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= avs_read ? rd_value : 32'h0000_0000;
      end else begin
        // back to waiting, so a held request is never answered in two cycles in a row
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // control register; only the low byte lane carries fields
  always @(posedge mclk) begin
    if (reset) begin
      ctrl_r <= `CTRL_RESET;
    end else if (clk_en) begin
      if (bus_wr_commit & (avs_address == `REG_CTRL) & avs_byteenable[0]) begin
        ctrl_r <= avs_writedata[1:0];
      end
    end
  end

endmodule // status_flag_bit_ops

//--- tb/flag_ops_checker.sv
// concurrent checks for the flag and bit transfer unit
`include "flag_ops_defs.vh"
module flag_ops_checker (
  input logic       mclk,
  input logic       reset,
  input logic       clk_en,
  input logic       op_valid,
  input logic [4:0] op_code,
  input logic [2:0] op_bit,
  input logic [7:0] op_reg_data,
  input logic       avs_write,
  input logic [7:0] status_flags_reg,
  input logic       reg_wr_en,
  input logic [7:0] reg_wr_data,
  input logic       sleep_req,
  input logic       wdog_restart,
  input logic       op_done
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (reset);
  // a same-cycle bus write may also move the flags, so it is left out
  wire       go = clk_en && op_valid && !avs_write;
  wire [7:0] fl = status_flags_reg;
  wire [7:0] mask = 8'h01 << op_code[3:1];
  wire [7:0] want = (fl & ~mask) | ({8{op_code[0]}} & mask);
  wire [7:0] merged = (op_reg_data & ~(8'h01 << op_bit)) | ({7'h0, fl[6]} << op_bit);
  wire [6:0] keep = {fl[7], fl[5:0]};
  wire       src = op_reg_data[op_bit];
  wire       named = go && op_code[4];
  wire       wd_go = go && op_code == `OP_WDOG_RESTART;
  // a bus write does not stop a restart, so the cause check ignores it
  wire       wd_any = clk_en && op_valid && op_code == `OP_WDOG_RESTART;
  a_copy_to_flag: assert property (go && op_code == `OP_COPY_BIT |=>
    op_done && fl[6] == $past(src) && keep == $past(keep)) else $error("copy bad");
  a_load_merge: assert property (go && op_code == `OP_LOAD_BIT |=>
    reg_wr_en && reg_wr_data == $past(merged) && $stable(fl)) else $error("load bad");
  a_ovf_force: assert property (named && op_code[3:1] == `FLAG_V |=>
    op_done && fl == $past(want)) else $error("overflow op bad");
  a_sign_force: assert property (named && op_code[3:1] == `FLAG_S |=>
    op_done && fl == $past(want)) else $error("sign op bad");
  a_half_force: assert property (named && op_code[3:1] == `FLAG_H |=>
    op_done && fl == $past(want)) else $error("half op bad");
  a_sleep_keep: assert property (go && op_code == `OP_SLEEP |=>
    sleep_req && $stable(fl)) else $error("sleep bad");
  a_wdog_pulse: assert property (wd_go |=> wdog_restart && op_done && $stable(fl))
    else $error("restart bad");
  a_wdog_cause: assert property (wdog_restart && $past(clk_en) |-> $past(wd_any))
    else $error("stray restart");
  a_named_other: assert property (named && (op_code[3:1] < 3 || op_code[3:1] > 5) |=>
    op_done && fl == $past(want)) else $error("named op bad");
  a_nop_idle: assert property (go && op_code == `OP_NOP |=>
    op_done && !reg_wr_en && $stable(fl)) else $error("nop bad");
  c_load: cover property (reg_wr_en);
  c_sleep: cover property (sleep_req);
  c_set: cover property (named && op_code[0]);
endmodule // flag_ops_checker
bind status_flag_bit_ops flag_ops_checker u_flag_ops_checker (.mclk, .reset, .clk_en,
  .op_valid, .op_code, .op_bit, .op_reg_data, .avs_write, .status_flags_reg, .reg_wr_en,
  .reg_wr_data, .sleep_req, .wdog_restart, .op_done);

//--- tb/testbench.sv
// self-checking bench for the flag and bit transfer unit
`include "flag_ops_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, reset, clk_en, op_valid, wake, rd, wr, we, sq, wq, dn, wt;
  logic [4:0]  op_code, wa;
  logic [2:0]  op_bit;
  logic [7:0]  op_reg_data, flags, wd, exp_f;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat, q;
  int          fails, check_count;
  status_flag_bit_ops u_status_flag_bit_ops (.mclk, .reset, .clk_en, .op_valid, .op_code,
    .op_bit, .op_reg_addr(5'h09), .op_reg_data, .wake, .status_flags_reg(flags),
    .reg_wr_en(we), .reg_wr_addr(wa), .reg_wr_data(wd), .sleep_req(sq), .wdog_restart(wq),
    .op_done(dn), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wt));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one bus access; the request stands until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    {wr, rd, adr, wdat} <= {w, !w, a, d};
    n = 0;
    // waitrequest and readdata are taken at the rising edge itself
    do begin
      @(posedge mclk);
      n++;
    end while (wt !== 1'b0 && n < 20);
    q = rdat;
    if (n >= 20) begin
      fails++;
      final_report();
    end
    {wr, rd} <= 2'b00;
  endtask
  // one instruction, answered in the next cycle
  task automatic op(input logic [4:0] c, input logic [2:0] b, input logic [7:0] d);
    @(posedge mclk);
    {op_valid, op_code, op_bit, op_reg_data} <= {1'b1, c, b, d};
    @(posedge mclk);
    op_valid <= 1'b0;
    @(negedge mclk);
    chk("op_done", 1, dn);
    chk("flags", exp_f, flags);
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    {reset, clk_en, op_valid, wake, rd, wr} = 6'b11_0000;
    {op_code, op_bit, op_reg_data, adr, wdat, fails, check_count} = '0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    bus(0, 4'h0, 0);
    chk("flags_rst", 0, q);
    bus(0, 4'h4, 0);
    chk("ctrl_rst", 3, q);
    bus(0, 4'h2, 0);
    chk("unmapped", 0, q);
    bus(1, 4'h0, 32'h0000_003c);
    exp_f = 8'h3c;
    // every named flag cleared, then every one set
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 8; i++) begin
        exp_f[i] = s[0];
        op({1'b1, 3'(i), s[0]}, 0, 0);
      end
    end
    exp_f[6] = 1'b0;
    op(`OP_COPY_BIT, 3'd1, 8'ha5);
    op(`OP_LOAD_BIT, 3'd4, 8'hff);
    chk("wr_data", 8'hef, wd);
    chk("wr_addr", 5'h09, wa);
    exp_f[6] = 1'b1;
    op(`OP_COPY_BIT, 3'd2, 8'ha5);
    op(`OP_LOAD_BIT, 3'd7, 8'h00);
    chk("wr_data", 8'h80, wd);
    op(`OP_NOP, 0, 0);
    chk("wr_en", 0, we);
    op(`OP_SLEEP, 0, 0);
    chk("sleep", 1, sq);
    bus(0, 4'h8, 0);
    chk("status", 32'h0000_0501, q);
    wake <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    bus(0, 4'h8, 0);
    chk("woken", 32'h0000_0500, q);
    op(`OP_WDOG_RESTART, 0, 0);
    chk("restart", 1, wq);
    bus(0, 4'hc, 0);
    chk("count", 23, q);
    // generic flag clear and set by bit index
    exp_f[3] = 1'b0;
    op(`OP_FLAG_CLEAR, 3'd3, 8'h00);
    exp_f[3] = 1'b1;
    op(`OP_FLAG_SET, 3'd3, 8'h00);
    final_report();
  end
endmodule // testbench
